//--- rtl/dprf_map.vh
// constants for the dual-port ram / fifo / ecc block
`ifndef DPRF_MAP_VH
`define DPRF_MAP_VH
// ****************************************
// port width codes (depth x width)
// ****************************************
`define DPRF_W1 3'h0
`define DPRF_W2 3'h1
`define DPRF_W4 3'h2
`define DPRF_W9 3'h3
`define DPRF_W18 3'h4
`define DPRF_W36 3'h5
`define DPRF_W72 3'h6
// ****************************************
// storage geometry, in 9-bit bytes
// ****************************************
`define DPRF_FULL_BYTES 13'h1000
`define DPRF_HALF_BYTES 13'h0800
`define DPRF_MEM_LAST 4095
// ****************************************
// reset values
// ****************************************
`define DPRF_PTR_RST 13'h0000
`define DPRF_WORD_RST 72'h000000000000000000
`endif

//--- rtl/dprf_top.v
// dual-port ram with split, simple two-port, ecc and fifo modes
`include "dprf_map.vh"

module dprf_top (
  input wire clock_in,
  input wire resetn_in,
  input wire split_in,
  input wire simple_two_port_mode_in,
  input wire ecc_en_in,
  input wire fifo_mode_in,
  input wire fifo_dual_clock_in,
  input wire [11:0] port_width_in,
  input wire [3:0] port_en_in,
  input wire [3:0] port_we_in,
  input wire [59:0] port_addr_in,
  input wire [287:0] port_wdata_in,
  output reg [287:0] port_rdata_out,
  output reg ecc_sbit_out,
  output reg ecc_dbit_out,
  input wire [2:0] fifo_wr_width_in,
  input wire [2:0] fifo_rd_width_in,
  input wire [12:0] fifo_afull_thr_in,
  input wire [12:0] fifo_aempty_thr_in,
  input wire fifo_wr_in,
  input wire [71:0] fifo_wdata_in,
  input wire fifo_rd_in,
  output wire [71:0] fifo_rdata_out,
  output wire fifo_full_out,
  output wire fifo_empty_out,
  output wire fifo_afull_out,
  output wire fifo_aempty_out,
  input wire cascade_in_en_in,
  input wire cascade_valid_in,
  input wire [71:0] cascade_data_in,
  output wire cascade_ready_out,
  input wire cascade_out_en_in,
  output wire cascade_valid_out,
  input wire cascade_ready_in,
  input wire [63:0] enc_data_in,
  output reg [7:0] enc_check_out,
  input wire [63:0] dec_data_in,
  input wire [7:0] dec_check_in,
  output reg [63:0] dec_data_out,
  output reg dec_sbit_out,
  output reg dec_dbit_out
);

  // ****************************************
  // storage: 4096 bytes of 8 data + 1 parity bit
  // ****************************************
  reg [8:0] mem [0:`DPRF_MEM_LAST];
  wire simple_two_port_mode = simple_two_port_mode_in;
  wire [11:0] eff_w;
  wire [47:0] base;
  wire [11:0] off;
  wire [3:0] wr;
  wire [3:0] rd;

  // hamming syndrome over 64 data bits placed at non-power-of-two positions
  function [6:0] ecc_syn;
    input [63:0] d;
    integer q, k;
    reg [6:0] s;
    begin
      s = 7'h00;
      k = 0;
      for (q = 1; q < 72; q = q + 1)
        if ((q & (q - 1)) != 0)
        begin
          if (d[k])
            s = s ^ q[6:0];
          k = k + 1;
        end
      ecc_syn = s;
    end
  endfunction

  // check byte: seven hamming bits plus overall parity
  function [7:0] ecc_chk;
    input [63:0] d;
    reg [6:0] s;
    begin
      s = ecc_syn(d);
      ecc_chk = {^{d, s}, s};
    end
  endfunction

  // returns {double error, single error, corrected data}
  function [65:0] ecc_dec;
    input [71:0] w;
    integer q, k;
    reg [6:0] s;
    reg pe;
    reg [63:0] d;
    begin
      d = w[63:0];
      s = ecc_syn(d) ^ w[70:64];
      pe = ^w;
      k = 0;
      for (q = 1; q < 72; q = q + 1)
        if ((q & (q - 1)) != 0)
        begin
          if (pe && q[6:0] == s)
            d[k] = ~d[k];
          k = k + 1;
        end
      ecc_dec = {(s != 7'h00) & ~pe, pe, d};
    end
  endfunction

  // word of width code w at byte b, bit offset o; data low, parity above
  function [71:0] rd_word;
    input [2:0] w;
    input [11:0] b;
    input [2:0] o;
    integer i, n;
    reg [8:0] by;
    begin
      rd_word = `DPRF_WORD_RST;
      if (w < `DPRF_W9)
      begin
        by = mem[b];
        for (i = 0; i < 8; i = i + 1)
          if (i < (1 << w))
            rd_word[i] = by[o + i];
      end
      else
      begin
        n = 1 << (w - `DPRF_W9);
        for (i = 0; i < 8; i = i + 1)
          if (i < n)
          begin
            by = mem[b + i];
            rd_word[8 * i +: 8] = by[7:0];
            rd_word[8 * n + i] = by[8];
          end
      end
    end
  endfunction

  // ****************************************
  // per-port width, address and access decode
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_port
      // widest legal code depends on split and two-port mode
      wire [2:0] lim = split_in ? (simple_two_port_mode ? `DPRF_W36 : `DPRF_W18)
                                : (simple_two_port_mode ? `DPRF_W72 : `DPRF_W36);
      wire [2:0] req_w = port_width_in[3*g+2:3*g];
      wire [2:0] par_w = port_width_in[3*(g^1)+2:3*(g^1)];
      wire [2:0] req_c = (req_w > lim) ? lim : req_w;
      wire [2:0] par_c = (par_w > lim) ? lim : par_w;
      // read side is pinned widest unless the write side already is
      wire [2:0] w = (simple_two_port_mode && (g % 2 == 1) && par_c < lim) ? lim : req_c;
      wire act = (g < 2) ? !fifo_mode_in : split_in;
      wire [14:0] a = port_addr_in[15*g+14:15*g];
      wire [14:0] sh = (w >= `DPRF_W9) ? (a << (w - `DPRF_W9))
                                        : (a >> (`DPRF_W9 - w));
      assign eff_w[3*g+2:3*g] = w;
      assign base[12*g+11:12*g] = {split_in ? (g >= 2) : sh[11], sh[10:0]};
      assign off[3*g+2:3*g] = (w >= `DPRF_W9) ? 3'h0 : (a[2:0] << w);
      assign wr[g] = act & port_en_in[g] & port_we_in[g] & !(simple_two_port_mode && g % 2 == 1);
      assign rd[g] = act & port_en_in[g] & !(simple_two_port_mode && g % 2 == 0);
    end
  endgenerate

  // ****************************************
  // ecc on the wide two-port path
  // ****************************************
  wire ecc_on = ecc_en_in & simple_two_port_mode & !split_in;
  wire ecc_w = ecc_on & (eff_w[2:0] == `DPRF_W72);
  wire ecc_r = ecc_on & (eff_w[5:3] == `DPRF_W72);
  wire [71:0] wd0 = ecc_w ? {ecc_chk(port_wdata_in[63:0]), port_wdata_in[63:0]}
                          : port_wdata_in[71:0];
  wire [287:0] wdata = {port_wdata_in[287:72], wd0};

  // ****************************************
  // fifo controller
  // ****************************************
  reg [12:0] wptr_q, rptr_q, wsync1_q, wsync2_q, rsync1_q, rsync2_q;
  reg [71:0] frd_q;
  reg cvalid_q;
  wire [2:0] fmax = split_in ? `DPRF_W36 : `DPRF_W72;
  wire [2:0] fw = (fifo_wr_width_in < `DPRF_W9) ? `DPRF_W9 :
                  (fifo_wr_width_in > fmax) ? fmax : fifo_wr_width_in;
  wire [2:0] fr = (fifo_rd_width_in < `DPRF_W9) ? `DPRF_W9 :
                  (fifo_rd_width_in > fmax) ? fmax : fifo_rd_width_in;
  wire [12:0] nbw = 13'h0001 << (fw - `DPRF_W9);
  wire [12:0] nbr = 13'h0001 << (fr - `DPRF_W9);
  wire [12:0] cap = split_in ? `DPRF_HALF_BYTES : `DPRF_FULL_BYTES;
  // dual-clock mode sees the far pointer two stages late, so flags stay safe
  wire [12:0] cnt_w = wptr_q - (fifo_dual_clock_in ? rsync2_q : rptr_q);
  wire [12:0] cnt_r = (fifo_dual_clock_in ? wsync2_q : wptr_q) - rptr_q;
  wire full = (cnt_w + nbw) > cap;
  wire empty = cnt_r < nbr;
  wire [71:0] fwd = cascade_in_en_in ? cascade_data_in : fifo_wdata_in;
  wire push_req = cascade_in_en_in ? cascade_valid_in : fifo_wr_in;
  wire push = fifo_mode_in & push_req & !full;
  wire pop = fifo_mode_in & !empty &
             (cascade_out_en_in ? (!cvalid_q | cascade_ready_in) : fifo_rd_in);
  wire [11:0] waddr = split_in ? {1'b0, wptr_q[10:0]} : wptr_q[11:0];
  wire [11:0] raddr = split_in ? {1'b0, rptr_q[10:0]} : rptr_q[11:0];

  assign fifo_full_out = fifo_mode_in & full;
  assign fifo_empty_out = !fifo_mode_in | empty;
  assign fifo_afull_out = fifo_mode_in & (cnt_w >= fifo_afull_thr_in);
  assign fifo_aempty_out = !fifo_mode_in | (cnt_r <= fifo_aempty_thr_in);
  assign cascade_ready_out = fifo_mode_in & cascade_in_en_in & !full;
  assign cascade_valid_out = cvalid_q;
  assign fifo_rdata_out = frd_q;

  // ****************************************
  // memory writes: later port wins a byte clash
  // ****************************************
  always @(posedge clock_in)
  begin : mem_wr
    integer p, i, n;
    reg [2:0] w;
    reg [11:0] b;
    reg [2:0] o;
    for (p = 0; p < 4; p = p + 1)
      if (wr[p])
      begin
        w = eff_w[3*p +: 3];
        b = base[12*p +: 12];
        o = off[3*p +: 3];
        if (w < `DPRF_W9)
        begin
          for (i = 0; i < 8; i = i + 1)
            if (i < (1 << w))
              mem[b][o + i] <= wdata[72 * p + i];
        end
        else
        begin
          n = 1 << (w - `DPRF_W9);
          for (i = 0; i < 8; i = i + 1)
            if (i < n)
              mem[b + i] <= {wdata[72 * p + 8 * n + i], wdata[72 * p + 8 * i +: 8]};
        end
      end
    if (push)
    begin
      n = 1 << (fw - `DPRF_W9);
      for (i = 0; i < 8; i = i + 1)
        if (i < n)
          mem[waddr + i] <= {fwd[8 * n + i], fwd[8 * i +: 8]};
    end
  end

  // ****************************************
  // port reads: read-before-write, one cycle latency
  // ****************************************
  always @(posedge clock_in or negedge resetn_in)
  begin : port_rd
    integer p;
    reg [71:0] rw;
    reg [65:0] dw;
    if (!resetn_in)
    begin
      port_rdata_out <= {4{`DPRF_WORD_RST}};
      ecc_sbit_out <= 1'b0;
      ecc_dbit_out <= 1'b0;
    end
    else
    begin
      for (p = 0; p < 4; p = p + 1)
        if (rd[p])
        begin
          rw = rd_word(eff_w[3*p +: 3], base[12*p +: 12], off[3*p +: 3]);
          if (p == 1 && ecc_r)
          begin
            dw = ecc_dec(rw);
            rw = {rw[71:64], dw[63:0]};
            ecc_sbit_out <= dw[64];
            ecc_dbit_out <= dw[65];
          end
          port_rdata_out[72 * p +: 72] <= rw;
        end
    end
  end

  // ****************************************
  // fifo pointers, pointer delay, output word
  // ****************************************
  always @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      wptr_q <= `DPRF_PTR_RST;
      rptr_q <= `DPRF_PTR_RST;
      wsync1_q <= `DPRF_PTR_RST;
      wsync2_q <= `DPRF_PTR_RST;
      rsync1_q <= `DPRF_PTR_RST;
      rsync2_q <= `DPRF_PTR_RST;
      frd_q <= `DPRF_WORD_RST;
      cvalid_q <= 1'b0;
    end
    else if (!fifo_mode_in)
    begin
      // leaving fifo mode empties it
      wptr_q <= `DPRF_PTR_RST;
      rptr_q <= `DPRF_PTR_RST;
      wsync1_q <= `DPRF_PTR_RST;
      wsync2_q <= `DPRF_PTR_RST;
      rsync1_q <= `DPRF_PTR_RST;
      rsync2_q <= `DPRF_PTR_RST;
      cvalid_q <= 1'b0;
    end
    else
    begin
      if (push)
        wptr_q <= wptr_q + nbw;
      if (pop)
      begin
        rptr_q <= rptr_q + nbr;
        frd_q <= rd_word(fr, raddr, 3'h0);
      end
      wsync1_q <= wptr_q;
      wsync2_q <= wsync1_q;
      rsync1_q <= rptr_q;
      rsync2_q <= rsync1_q;
      if (!cascade_out_en_in)
        cvalid_q <= 1'b0;
      else if (pop)
        cvalid_q <= 1'b1;
      else if (cascade_ready_in)
        cvalid_q <= 1'b0;
    end
  end

  // ****************************************
  // standalone encoder and decoder for external memory
  // ****************************************
  always @(posedge clock_in or negedge resetn_in)
  begin : ext_ecc
    reg [65:0] dw;
    if (!resetn_in)
    begin
      enc_check_out <= 8'h00;
      dec_data_out <= 64'h0000000000000000;
      dec_sbit_out <= 1'b0;
      dec_dbit_out <= 1'b0;
    end
    else
    begin
      dw = ecc_dec({dec_check_in, dec_data_in});
      enc_check_out <= ecc_chk(enc_data_in);
      dec_data_out <= dw[63:0];
      dec_sbit_out <= dw[64];
      dec_dbit_out <= dw[65];
    end
  end

endmodule // dprf_top

//--- tb/dprf_top_asserts.sv
// assertions on fifo flags, cascade handshake and ecc decoder
module dprf_top_asserts (
  input logic clock_in,
  input logic resetn_in,
  input logic fifo_mode_in,
  input logic fifo_dual_clock_in,
  input logic fifo_wr_in,
  input logic fifo_rd_in,
  input logic [71:0] fifo_rdata_out,
  input logic fifo_full_out,
  input logic fifo_empty_out,
  input logic fifo_afull_out,
  input logic fifo_aempty_out,
  input logic cascade_in_en_in,
  input logic cascade_out_en_in,
  input logic cascade_ready_out,
  input logic cascade_valid_out,
  input logic cascade_ready_in,
  input logic [63:0] dec_data_in,
  input logic [7:0] dec_check_in,
  input logic [63:0] dec_data_out,
  input logic dec_sbit_out,
  input logic dec_dbit_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!resetn_in);
  // full and empty hold checks only in single clock: dual clock flags lag the far pointer
  property p_full;
    fifo_mode_in && !fifo_dual_clock_in && fifo_full_out && !fifo_rd_in && !cascade_out_en_in
      ##1 fifo_mode_in |-> fifo_full_out;
  endproperty
  a_full: assert property (p_full) else $error("full dropped");
  property p_empty;
    fifo_mode_in && !fifo_dual_clock_in && fifo_empty_out && !fifo_wr_in && !cascade_in_en_in
      ##1 fifo_mode_in |-> fifo_empty_out && $stable(fifo_rdata_out);
  endproperty
  a_empty: assert property (p_empty) else $error("empty changed");
  property p_idle;
    !fifo_mode_in |-> !fifo_full_out && fifo_empty_out && fifo_aempty_out && !fifo_afull_out;
  endproperty
  a_idle: assert property (p_idle) else $error("idle flags");
  property p_crdy;
    cascade_ready_out == (fifo_mode_in && cascade_in_en_in && !fifo_full_out);
  endproperty
  a_crdy: assert property (p_crdy) else $error("cascade ready");
  property p_chold;
    cascade_out_en_in && cascade_valid_out && !cascade_ready_in ##1 cascade_out_en_in
      |-> cascade_valid_out && $stable(fifo_rdata_out);
  endproperty
  a_chold: assert property (p_chold) else $error("cascade hold");
  property p_lag;
    (fifo_mode_in && fifo_dual_clock_in && !fifo_wr_in && !cascade_in_en_in) [*2]
      ##1 fifo_dual_clock_in && fifo_empty_out && fifo_wr_in ##1 fifo_mode_in |-> fifo_empty_out;
  endproperty
  a_lag: assert property (p_lag) else $error("dual lag");
  property p_dclean;
    dec_data_in == 64'h0 && dec_check_in == 8'h00
      |=> !dec_sbit_out && !dec_dbit_out && dec_data_out == 64'h0;
  endproperty
  a_dclean: assert property (p_dclean) else $error("clean word");
  property p_dfix;
    dec_data_in == 64'h1 && dec_check_in == 8'h00
      |=> dec_sbit_out && !dec_dbit_out && dec_data_out == 64'h0;
  endproperty
  a_dfix: assert property (p_dfix) else $error("single fix");
  c_full: cover property (fifo_full_out);
  c_hand: cover property (cascade_valid_out && cascade_ready_in);
  c_sbit: cover property (dec_sbit_out);
endmodule // dprf_top_asserts
bind dprf_top dprf_top_asserts dprf_top_asserts_i (.*);

//--- tb/dprf_fabric_model.sv
// fabric consumer on the fifo cascade output
module dprf_fabric_model (
  input logic clock_in,
  input logic resetn_in,
  input logic stall_in,
  input logic valid_in,
  input logic [71:0] data_in,
  output logic ready_out,
  output int taken_out,
  output logic [71:0] first_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // slow mode gives ready every other cycle so the fifo must hold its word
  always @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      ready_out <= 1'b0;
      taken_out <= 0;
      first_out <= 72'h0;
    end
    else
    begin
      ready_out <= stall_in ? !ready_out : 1'b1;
      if (valid_in && ready_out)
      begin
        taken_out <= taken_out + 1;
        if (taken_out == 0)
          first_out <= data_in;
      end
    end
  end
endmodule // dprf_fabric_model

//--- tb/dprf_top_test.sv
// self-checking bench for the dual-port ram, fifo and ecc block
module dprf_top_test;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {logic [63:0] d; logic [71:0] flip; logic sb; logic db;} dprf_row_t;
  logic clock_in, resetn_in, split_in, simple_two_port_mode_in, ecc_en_in, fifo_mode_in;
  logic fifo_dual_clock_in, ecc_sbit_out, ecc_dbit_out, fifo_wr_in, fifo_rd_in, fifo_full_out;
  logic fifo_empty_out, fifo_afull_out, fifo_aempty_out, cascade_in_en_in, cascade_valid_in;
  logic cascade_ready_out, cascade_out_en_in, cascade_valid_out, cascade_ready_in, stall_slow;
  logic dec_sbit_out, dec_dbit_out;
  logic [2:0] fifo_wr_width_in, fifo_rd_width_in;
  logic [3:0] port_en_in, port_we_in;
  logic [7:0] enc_check_out, dec_check_in;
  logic [11:0] port_width_in;
  logic [12:0] fifo_afull_thr_in, fifo_aempty_thr_in;
  logic [59:0] port_addr_in;
  logic [63:0] enc_data_in, dec_data_in, dec_data_out;
  logic [71:0] fifo_wdata_in, fifo_rdata_out, cascade_data_in, first_word;
  logic [287:0] port_wdata_in, port_rdata_out;
  int taken, miscompares, compares, n;
  // flip is applied to {check, data}
  dprf_row_t rows [5] = '{
    '{64'h0123456789ABCDEF, 72'h0, 1'b0, 1'b0},
    '{64'h0123456789ABCDEF, 72'h20, 1'b1, 1'b0},
    '{64'h0123456789ABCDEF, 72'h080000000000000000, 1'b1, 1'b0},
    '{64'h0123456789ABCDEF, 72'h201, 1'b0, 1'b1},
    '{64'h0, 72'h1, 1'b1, 1'b0}};
  dprf_top dprf_top_i (.*);
  dprf_fabric_model dprf_fabric_model_i (.clock_in(clock_in), .resetn_in(resetn_in),
    .stall_in(stall_slow), .valid_in(cascade_valid_out), .data_in(fifo_rdata_out),
    .ready_out(cascade_ready_in), .taken_out(taken), .first_out(first_word));
  always #12.5 clock_in = ~clock_in;
  task automatic tick();
    @(posedge clock_in);
    #2;
  endtask
  task automatic chk(input logic [71:0] got, input logic [71:0] exp);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    {clock_in, resetn_in, split_in, simple_two_port_mode_in, ecc_en_in, fifo_mode_in} = 6'h00;
    {fifo_dual_clock_in, fifo_wr_in, fifo_rd_in, cascade_in_en_in, cascade_valid_in} = 5'h00;
    {cascade_out_en_in, stall_slow, port_en_in, port_we_in} = 10'h000;
    {port_addr_in, port_wdata_in, cascade_data_in} = 420'h0;
    {enc_data_in, dec_data_in, dec_check_in} = 136'h0;
    port_width_in = 12'h01D;
    fifo_wr_width_in = 3'h6;
    fifo_rd_width_in = 3'h3;
    fifo_afull_thr_in = 13'h0FA0;
    fifo_aempty_thr_in = 13'h0009;
    fifo_wdata_in = 72'h0100000000000000AB;
    miscompares = 0;
    compares = 0;
    repeat (10) @(posedge clock_in);
    #2;
    resetn_in = 1'b1;
    chk(port_rdata_out[71:0], 72'h0);
    chk(cascade_valid_out, 1'b0);
    $display("test reset done");
    foreach (rows[i])
    begin
      enc_data_in = rows[i].d;
      tick();
      {dec_check_in, dec_data_in} = {enc_check_out, rows[i].d} ^ rows[i].flip;
      tick();
      chk(dec_sbit_out, rows[i].sb);
      chk(dec_dbit_out, rows[i].db);
      if (!rows[i].db)
        chk(dec_data_out, rows[i].d);
    end
    $display("test ecc done");
    // port0 x36 writes word 1, port1 x9 reads byte 5 of it
    {port_en_in, port_we_in} = 8'h11;
    port_addr_in[14:0] = 15'h0001;
    port_wdata_in[35:0] = 36'hA12345678;
    tick();
    {port_en_in, port_we_in} = 8'h20;
    port_addr_in[29:15] = 15'h0005;
    tick();
    port_en_in = 4'h0;
    chk(port_rdata_out[143:72], 72'h156);
    $display("test ram done");
    fifo_mode_in = 1'b1;
    tick();
    chk(fifo_aempty_out, 1'b1);
    fifo_wr_in = 1'b1;
    n = 0;
    while (fifo_full_out !== 1'b1 && n < 600)
    begin
      tick();
      n++;
    end
    {cascade_in_en_in, cascade_valid_in, cascade_data_in} = {2'h3, 72'h55};
    tick();
    chk(cascade_ready_out, 1'b0);
    {fifo_wr_in, cascade_in_en_in, cascade_valid_in} = 3'h0;
    chk(n, 512);
    chk(fifo_full_out, 1'b1);
    chk(fifo_afull_out, 1'b1);
    if (n >= 600)
      end_sim();
    {stall_slow, cascade_out_en_in} = 2'h3;
    n = 0;
    while ((fifo_empty_out !== 1'b1 || cascade_valid_out !== 1'b0) && n < 20000)
    begin
      tick();
      n++;
    end
    cascade_out_en_in = 1'b0;
    chk(taken, 4096);
    chk(first_word, 72'h1AB);
    if (n >= 20000)
      end_sim();
    fifo_rd_in = 1'b1;
    tick();
    fifo_rd_in = 1'b0;
    chk(fifo_empty_out, 1'b1);
    chk(fifo_rdata_out, 72'h0);
    // dual clock: the read side sees the push two cycles late
    {fifo_dual_clock_in, fifo_wr_width_in} = 4'hB;
    repeat (2) tick();
    fifo_wr_in = 1'b1;
    tick();
    fifo_wr_in = 1'b0;
    chk(fifo_empty_out, 1'b1);
    repeat (2) tick();
    chk(fifo_empty_out, 1'b0);
    $display("test fifo done");
    // simple two-port with ecc: port0 writes x72, port1 reads it back corrected
    {fifo_mode_in, simple_two_port_mode_in, ecc_en_in} = 3'h3;
    port_width_in = 12'h036;
    port_addr_in = 60'h0;
    port_wdata_in[71:0] = {8'h00, rows[0].d};
    {port_en_in, port_we_in} = 8'h11;
    tick();
    {port_en_in, port_we_in} = 8'h20;
    tick();
    chk(port_rdata_out[135:72], rows[0].d);
    chk({ecc_dbit_out, ecc_sbit_out}, 2'h0);
    // raw word with data bit 0 flipped; zero data has a zero check byte
    ecc_en_in = 1'b0;
    port_wdata_in[71:0] = 72'h1;
    {port_en_in, port_we_in} = 8'h11;
    tick();
    ecc_en_in = 1'b1;
    {port_en_in, port_we_in} = 8'h20;
    tick();
    port_en_in = 4'h0;
    chk(port_rdata_out[135:72], 64'h0);
    chk({ecc_dbit_out, ecc_sbit_out}, 2'h1);
    $display("test sdp ecc done");
    end_sim();
  end
endmodule // dprf_top_test
